/* File: logic/acrb_bank.sv */
/*
 Register bank of the analog combo block: amplifier, gain ladder and
 converter controls, converter data latch, flag, vector and DMA request.
 Assumes a single-cycle register port (strobes never both high), triggers
 and DMA start synchronous to clock, and one clock enable freezing state.
*/
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module acrb_bank
  import acrb_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [ACRB_AW-1:0] addr,
  input wire logic [ACRB_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [ACRB_DW-1:0] rdata,
  input wire logic trig_0,
  input wire logic trig_1,
  input wire logic dma_start,
  output logic block_on,
  output logic amp_on,
  output logic amp_out_hiz,
  output logic amp_power_mode,
  output logic neg_input_connect,
  output logic [1:0] neg_source_select,
  output logic pos_input_connect,
  output logic [1:0] pos_source_select,
  output logic [2:0] ladder_gain,
  output logic [1:0] ladder_mode_select,
  output logic conv_on,
  output logic conv_reference_select,
  output logic [ACRB_CW-1:0] conv_latch,
  output logic conv_irq,
  output logic conv_dma_req
);

  logic [15:0] amp_ctl;
  logic [15:0] gain_ctl;
  logic [15:0] conv_ctl;
  logic [ACRB_CW-1:0] conv_data_word;
  logic conv_irq_flag;
  logic trig_0_prev;
  logic trig_1_prev;

  function automatic logic hit(input logic [ACRB_AW-1:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Odd offsets decode to nothing, so byte accesses fall through [RULE1]
  wire sel_amp = hit(addr, OFS_AMP);
  wire sel_gain = hit(addr, OFS_GAIN);
  wire sel_cctl = hit(addr, OFS_CCTL);
  wire sel_cdat = hit(addr, OFS_CDAT);
  wire sel_csts = hit(addr, OFS_CSTS);
  wire sel_ivec = hit(addr, OFS_IVEC);

  wire block_enable = amp_ctl[AMP_BLOCK_EN];
  wire amp_enable = amp_ctl[AMP_EN];
  wire conv_enable = conv_ctl[CC_EN];
  wire conv_irq_enable = conv_ctl[CC_IE];
  wire conv_dma_enable = conv_ctl[CC_DMA];
  wire [1:0] conv_load_select = conv_ctl[CC_LSEL+:2];

  wire wr_amp = ce && wr && sel_amp;
  wire wr_gain = ce && wr && sel_gain;
  wire wr_cctl = ce && wr && sel_cctl;
  wire wr_cdat = ce && wr && sel_cdat;
  wire wr_csts = ce && wr && sel_csts;
  wire rd_ivec = ce && rd && sel_ivec;

  // Fields stay frozen while running; only the enable bit stays writable [RULE12]
  wire cctl_open = !conv_enable;
  wire [15:0] next_conv_ctl = cctl_open ? (wdata & CC_MASK) :
    ((conv_ctl & ~(16'h0001 << CC_EN)) | (wdata & (16'h0001 << CC_EN)));

  // Edge of the selected trigger; loads only while the converter runs [RULE14]
  wire trig_rise_0 = trig_0 && !trig_0_prev;
  wire trig_rise_1 = trig_1 && !trig_1_prev;
  wire trig_sel = conv_load_select[0] ? trig_rise_1 : trig_rise_0;
  wire trig_load = ce && conv_load_select[1] && conv_enable && trig_sel;
  wire write_load = wr_cdat && (conv_load_select == LSEL_WRITE);

  // Flag clear by write of one, vector read or transfer start; a new load wins [RULE16]
  wire flag_clr = (wr_csts && wdata[CS_FLAG]) || rd_ivec || (ce && dma_start);
  wire next_flag = trig_load || (conv_irq_flag && !flag_clr);

  wire [15:0] ivec_word = conv_irq_flag ? IVEC_CONV : IVEC_RST;
  wire [15:0] cdat_word = {{(16-ACRB_CW){1'b0}}, conv_data_word};
  wire [15:0] csts_word = {15'h0000, conv_irq_flag};

  // Unmapped and odd offsets read as zero [RULE18]
  wire [15:0] rd_mux =
    sel_amp ? amp_ctl :
    sel_gain ? gain_ctl :
    sel_cctl ? conv_ctl :
    sel_cdat ? cdat_word :
    sel_csts ? csts_word :
    sel_ivec ? ivec_word : 16'h0000;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      amp_ctl <= AMP_RST;
      gain_ctl <= GAIN_RST;
    end else begin
      if (wr_amp) begin
        amp_ctl <= wdata & AMP_MASK; // [RULE18]
      end
      if (wr_gain) begin
        gain_ctl <= wdata & GAIN_MASK; // [RULE10] [RULE11]
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conv_ctl <= CC_RST;
    end else if (wr_cctl) begin
      conv_ctl <= next_conv_ctl; // [RULE12] [RULE13]
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conv_data_word <= CDAT_RST[ACRB_CW-1:0];
      conv_latch <= CDAT_RST[ACRB_CW-1:0];
    end else begin
      if (wr_cdat) begin
        conv_data_word <= wdata[ACRB_CW-1:0]; // [RULE15]
      end
      if (write_load) begin
        conv_latch <= wdata[ACRB_CW-1:0]; // [RULE14]
      end else if (trig_load) begin
        conv_latch <= conv_data_word; // [RULE14]
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conv_irq_flag <= 1'b0;
      conv_dma_req <= 1'b0;
      trig_0_prev <= 1'b0;
      trig_1_prev <= 1'b0;
    end else if (ce) begin
      trig_0_prev <= trig_0;
      trig_1_prev <= trig_1;
      conv_irq_flag <= next_flag; // [RULE16]
      if (trig_load && conv_dma_enable) begin
        conv_dma_req <= 1'b1; // [RULE17]
      end else if (dma_start) begin
        conv_dma_req <= 1'b0; // [RULE17]
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= rd ? rd_mux : 16'h0000; // [RULE2] [RULE15] [RULE18]
    end
  end

  // Block enable gates the amplifier, both input connects and the converter enable [RULE3]
  assign block_on = block_enable;
  assign amp_on = block_enable && amp_enable; // [RULE5]
  assign amp_out_hiz = !amp_on; // [RULE3] [RULE5]
  assign amp_power_mode = amp_ctl[AMP_PWR]; // [RULE4]
  assign neg_input_connect = block_enable && amp_ctl[AMP_NCON]; // [RULE6]
  assign neg_source_select = amp_ctl[AMP_NEG_SOURCE_SELECT+:2]; // [RULE7]
  assign pos_input_connect = block_enable && amp_ctl[AMP_PCON]; // [RULE8]
  assign pos_source_select = amp_ctl[AMP_PSEL+:2]; // [RULE9]
  assign ladder_gain = gain_ctl[GAIN_CODE+:3]; // [RULE10]
  assign ladder_mode_select = gain_ctl[GAIN_MODE+:2]; // [RULE11]
  assign conv_on = block_enable && conv_enable; // [RULE3]
  assign conv_reference_select = conv_ctl[CC_REF]; // [RULE13]
  // Interrupt request is only the gated flag; the system controller arbitrates
  assign conv_irq = conv_irq_flag && conv_irq_enable;

  property p_ivec_read;
    @(posedge clock) disable iff (!resetn)
      (rd_ivec && conv_irq_flag && !trig_load) |=> (rdata == IVEC_CONV) && !conv_irq_flag;
  endproperty
  a_ivec_read: assert property (p_ivec_read) else $error("vector read did not clear flag"); // [RULE2]

  property p_ivec_write;
    @(posedge clock) disable iff (!resetn)
      (ce && wr && sel_ivec && !conv_irq_flag && !trig_load) |=> !conv_irq_flag;
  endproperty
  a_ivec_write: assert property (p_ivec_write) else $error("vector write changed state"); // [RULE2]

  property p_block_off;
    @(posedge clock) disable iff (!resetn)
      !block_enable |-> !amp_on && !conv_on && amp_out_hiz && !neg_input_connect && !pos_input_connect;
  endproperty
  a_block_off: assert property (p_block_off) else $error("sub-module active with block off"); // [RULE3]

  property p_cctl_lock;
    @(posedge clock) disable iff (!resetn)
      (wr_cctl && conv_enable) |=> $stable(conv_ctl[15:1]);
  endproperty
  a_cctl_lock: assert property (p_cctl_lock) else $error("control changed while running"); // [RULE12]

  property p_cdat_read;
    @(posedge clock) disable iff (!resetn)
      (ce && rd && sel_cdat) |=> (rdata[15:ACRB_CW] == 4'h0) && (rdata[ACRB_CW-1:0] == $past(conv_data_word));
  endproperty
  a_cdat_read: assert property (p_cdat_read) else $error("data read wrong"); // [RULE15]

  property p_trig_flag;
    @(posedge clock) disable iff (!resetn)
      trig_load |=> conv_irq_flag && (conv_latch == $past(conv_data_word));
  endproperty
  a_trig_flag: assert property (p_trig_flag) else $error("trigger load did not set flag"); // [RULE16]

  property p_write_noflag;
    @(posedge clock) disable iff (!resetn)
      (ce && conv_load_select == LSEL_WRITE && !conv_irq_flag) |=> !conv_irq_flag;
  endproperty
  a_write_noflag: assert property (p_write_noflag) else $error("flag set in direct mode"); // [RULE14]

  property p_dma_clear;
    @(posedge clock) disable iff (!resetn)
      (ce && dma_start && !trig_load) |=> !conv_dma_req && !conv_irq_flag;
  endproperty
  a_dma_clear: assert property (p_dma_clear) else $error("transfer start did not clear"); // [RULE17]

  property p_dma_raise;
    @(posedge clock) disable iff (!resetn)
      (trig_load && conv_dma_enable) |=> conv_dma_req;
  endproperty
  a_dma_raise: assert property (p_dma_raise) else $error("no DMA request after load"); // [RULE17]

  property p_gain_write;
    @(posedge clock) disable iff (!resetn)
      wr_gain |=> (ladder_mode_select == $past(wdata[1:0])) && (gain_ctl[15:7] == 9'h000);
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain word write wrong"); // [RULE11]

  property p_rdata_idle;
    @(posedge clock) disable iff (!resetn)
      (ce && !rd) |=> (rdata == 16'h0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot"); // [RULE1]

  property p_odd_write;
    @(posedge clock) disable iff (!resetn)
      (ce && wr && addr[0]) |=> $stable(amp_ctl) && $stable(gain_ctl) && $stable(conv_ctl) && $stable(conv_data_word);
  endproperty
  a_odd_write: assert property (p_odd_write) else $error("odd offset write landed"); // [RULE1]

  property p_amp_write;
    @(posedge clock) disable iff (!resetn)
      wr_amp |=> (amp_ctl == ($past(wdata) & AMP_MASK));
  endproperty
  a_amp_write: assert property (p_amp_write) else $error("amplifier word write wrong"); // [RULE18]

  property p_cctl_open;
    @(posedge clock) disable iff (!resetn)
      (wr_cctl && !conv_enable) |=> (conv_ctl == ($past(wdata) & CC_MASK));
  endproperty
  a_cctl_open: assert property (p_cctl_open) else $error("converter control write wrong"); // [RULE13]

  property p_cctl_enable_bit;
    @(posedge clock) disable iff (!resetn)
      (wr_cctl && conv_enable) |=> (conv_ctl[CC_EN] == $past(wdata[CC_EN]));
  endproperty
  a_cctl_enable_bit: assert property (p_cctl_enable_bit) else $error("enable bit not writable"); // [RULE12]

  property p_write_load;
    @(posedge clock) disable iff (!resetn)
      write_load |=> (conv_latch == $past(wdata[ACRB_CW-1:0]));
  endproperty
  a_write_load: assert property (p_write_load) else $error("direct load missed"); // [RULE14]

  property p_rsvd_load;
    @(posedge clock) disable iff (!resetn)
      (conv_load_select == LSEL_RSVD) |=> $stable(conv_latch);
  endproperty
  a_rsvd_load: assert property (p_rsvd_load) else $error("latch loaded in reserved mode"); // [RULE14]

  property p_trig_off;
    @(posedge clock) disable iff (!resetn)
      (!conv_enable && conv_load_select[1]) |=> $stable(conv_latch);
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("latch loaded while disabled"); // [RULE14]

  property p_flag_write_clr;
    @(posedge clock) disable iff (!resetn)
      (wr_csts && wdata[CS_FLAG] && !trig_load) |=> !conv_irq_flag;
  endproperty
  a_flag_write_clr: assert property (p_flag_write_clr) else $error("write one did not clear flag"); // [RULE16]

  property p_csts_read;
    @(posedge clock) disable iff (!resetn)
      (ce && rd && sel_csts) |=> (rdata == {15'h0000, $past(conv_irq_flag)});
  endproperty
  a_csts_read: assert property (p_csts_read) else $error("status read wrong"); // [RULE16]

  property p_ivec_idle;
    @(posedge clock) disable iff (!resetn)
      (rd_ivec && !conv_irq_flag) |=> (rdata == IVEC_RST);
  endproperty
  a_ivec_idle: assert property (p_ivec_idle) else $error("vector not zero when idle"); // [RULE2]

  property p_dma_hold;
    @(posedge clock) disable iff (!resetn)
      (conv_dma_req && !(ce && dma_start)) |=> conv_dma_req;
  endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("DMA request dropped early"); // [RULE17]

endmodule : acrb_bank

/* File: shared/acrb_pkg.sv */
/*
 Constants for the analog combo register bank: offsets, field positions,
 reset values and codes.
 Assumes a 16-bit word port with byte offsets; only even offsets are words.
*/
// Notes on behaviour
// RULE1: Six word registers at even offsets 00h to 0Ah; odd offsets are ignored.
// RULE2: Interrupt vector word is read only, resets to zero, writes ignored.
// RULE3: Block enable at bit 10; clear disables everything, output goes high impedance. Ladder outputs and triggered latch loads are not gated by it.
// RULE4: Power mode bit 9: zero high speed and power, one low speed and power.
// RULE5: Amplifier enable bit 8; clear disables amplifier, output high impedance.
// RULE6: Bit 7 connects all negative sources to the inverting port.
// RULE7: Bits 5-4 pick negative source: pin, ladder, device source, reserved.
// RULE8: Bit 3 connects all positive sources to the non-inverting port.
// RULE9: Bits 1-0 pick positive source: pin, converter, paired amplifier, reserved.
// RULE10: Three-bit gain code in bits 6-4, reset zero, sent to the ladder.
// RULE11: Mode bits 1-0 select ladder mode; reset value of word is 0001h.
// RULE12: Converter control writes are blocked while converter enable is one. The enable bit itself stays writable.
// RULE13: Reference bit 12, load select 9-8, DMA 2, irq 1, enable 0.
// RULE14: Load select 00 loads on data write, 01 reserved, 1x on trigger edge.
// RULE15: Converter data is unsigned 12-bit in bits 11-0; upper bits read zero.
// RULE16: Triggered load sets flag; write one or vector read clears it.
// RULE17: DMA request rises on load with enable; transfer start clears request and flag.
// RULE18: Reserved bits read as zero and ignore writes.
package acrb_pkg;
  localparam int ACRB_AW = 4;
  localparam int ACRB_DW = 16;
  localparam int ACRB_CW = 12;
  localparam logic [3:0] OFS_AMP = 4'h0;
  localparam logic [3:0] OFS_GAIN = 4'h2;
  localparam logic [3:0] OFS_CCTL = 4'h4;
  localparam logic [3:0] OFS_CDAT = 4'h6;
  localparam logic [3:0] OFS_CSTS = 4'h8;
  localparam logic [3:0] OFS_IVEC = 4'hA;
  // Amplifier control word
  localparam int AMP_BLOCK_EN = 10;
  localparam int AMP_PWR = 9;
  localparam int AMP_EN = 8;
  localparam int AMP_NCON = 7;
  localparam int AMP_NEG_SOURCE_SELECT = 4;
  localparam int AMP_PCON = 3;
  localparam int AMP_PSEL = 0;
  localparam logic [15:0] AMP_MASK = 16'h07bb;
  localparam logic [15:0] AMP_RST = 16'h0000;
  // Gain and mode word
  localparam int GAIN_CODE = 4;
  localparam int GAIN_MODE = 0;
  localparam logic [15:0] GAIN_MASK = 16'h0073;
  localparam logic [15:0] GAIN_RST = 16'h0001;
  // Converter control word
  localparam int CC_REF = 12;
  localparam int CC_LSEL = 8;
  localparam int CC_DMA = 2;
  localparam int CC_IE = 1;
  localparam int CC_EN = 0;
  localparam logic [15:0] CC_MASK = 16'h1307;
  localparam logic [15:0] CC_RST = 16'h0000;
  localparam logic [15:0] CDAT_RST = 16'h0000;
  localparam int CS_FLAG = 0;
  localparam logic [15:0] IVEC_RST = 16'h0000;
  // Vector code shown while the converter flag is pending
  localparam logic [15:0] IVEC_CONV = 16'h0002;
  localparam logic [1:0] LSEL_WRITE = 2'h0;
  localparam logic [1:0] LSEL_RSVD = 2'h1;
endpackage : acrb_pkg

/* File: tb/test_analog_combo_register_bank.sv */
/*
 Self-checking bench for the analog combo register bank: register reset values,
 masks, locks, converter latch loading, flag, vector and DMA request.
 Assumes acrb_bank with the single-cycle register port and one 100 MHz clock.
*/
`timescale 1ns/1ps
module test_analog_combo_register_bank;
  import acrb_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic trig_0 = 1'b0, trig_1 = 1'b0, dma_start = 1'b0;
  logic [ACRB_AW-1:0] addr = 4'h0;
  logic [ACRB_DW-1:0] wdata = 16'h0000;
  logic [ACRB_DW-1:0] rdata;
  logic block_on, amp_on, amp_out_hiz, amp_power_mode, neg_input_connect, pos_input_connect;
  logic [1:0] neg_source_select, pos_source_select, ladder_mode_select;
  logic [2:0] ladder_gain;
  logic conv_on, conv_reference_select, conv_irq, conv_dma_req;
  logic [ACRB_CW-1:0] conv_latch;
  int n_errors = 0;
  int check_count = 0;
  // Amplifier writes, read-back and {block, amp, hiz, power, ncon, neg_source_select, pcon, psel}
  logic [15:0] amp_w[5] = '{16'hffff, 16'h0100, 16'h04a8, 16'h0511, 16'h0432};
  logic [15:0] amp_r[5] = '{16'h07bb, 16'h0100, 16'h04a8, 16'h0511, 16'h0432};
  logic [15:0] amp_o[5] = '{16'h037f, 16'h0080, 16'h02b4, 16'h0309, 16'h029a};
  logic [15:0] gain_w[4] = '{16'hffff, 16'h0040, 16'h0022, 16'h0011};
  logic [15:0] gain_r[4] = '{16'h0073, 16'h0040, 16'h0022, 16'h0011};
  wire [15:0] amp_outs = {6'h00, block_on, amp_on, amp_out_hiz, amp_power_mode, neg_input_connect,
    neg_source_select, pos_input_connect, pos_source_select};
  wire [15:0] conv_outs = {conv_latch, conv_on, conv_reference_select, conv_irq, conv_dma_req};

  always #5 clock = ~clock;

  acrb_bank DUT (.clock(clock), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trig_0(trig_0), .trig_1(trig_1), .dma_start(dma_start), .block_on(block_on),
    .amp_on(amp_on), .amp_out_hiz(amp_out_hiz), .amp_power_mode(amp_power_mode),
    .neg_input_connect(neg_input_connect), .neg_source_select(neg_source_select),
    .pos_input_connect(pos_input_connect), .pos_source_select(pos_source_select),
    .ladder_gain(ladder_gain), .ladder_mode_select(ladder_mode_select), .conv_on(conv_on),
    .conv_reference_select(conv_reference_select), .conv_latch(conv_latch), .conv_irq(conv_irq),
    .conv_dma_req(conv_dma_req));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_errors++;
    end
  endtask : chk

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask : wreg

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rreg(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask : rreg

  // 0: trig_0, 1: trig_1, 2: dma_start; one high cycle, then a settle cycle
  task automatic pulse(input int which);
    @(posedge clock);
    trig_0 <= (which == 0);
    trig_1 <= (which == 1);
    dma_start <= (which == 2);
    @(posedge clock);
    trig_0 <= 1'b0;
    trig_1 <= 1'b0;
    dma_start <= 1'b0;
    @(posedge clock);
    #1;
  endtask : pulse

  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge clock);
    $display("watchdog expired");
    n_errors++;
    test_done();
  end

  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    #1;
    chk("reset amp outputs", 16'h0080, amp_outs);
    chk("reset mode", 16'h0001, {14'h0000, ladder_mode_select});
    rreg(OFS_AMP, 16'h0000, "amp_control");
    rreg(OFS_GAIN, 16'h0001, "gain_mode_control");
    rreg(OFS_CCTL, 16'h0000, "converter_control");
    rreg(OFS_CDAT, 16'h0000, "converter_data");
    rreg(OFS_CSTS, 16'h0000, "converter_status");
    rreg(OFS_IVEC, 16'h0000, "irq_vector");
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wreg(OFS_AMP, amp_w[i]);
      chk("amp outputs", amp_o[i], amp_outs);
      rreg(OFS_AMP, amp_r[i], "amp_control");
    end
    for (int i = 0; i < 4; i++) begin
      wreg(OFS_GAIN, gain_w[i]);
      chk("ladder outputs", {11'h000, gain_r[i][6:4], gain_r[i][1:0]}, {11'h000, ladder_gain, ladder_mode_select});
      rreg(OFS_GAIN, gain_r[i], "gain_mode_control");
    end
    $display("test amp and gain done");
    wreg(OFS_IVEC, 16'hffff);
    rreg(OFS_IVEC, 16'h0000, "irq_vector write");
    wreg(4'h3, 16'hffff);
    rreg(OFS_GAIN, 16'h0011, "gain after odd write");
    wreg(4'hc, 16'hffff);
    rreg(4'hc, 16'h0000, "unmapped read");
    rreg(4'h1, 16'h0000, "odd read");
    @(posedge clock);
    ce <= 1'b0;
    wreg(OFS_GAIN, 16'h0000);
    @(posedge clock);
    ce <= 1'b1;
    rreg(OFS_GAIN, 16'h0011, "gain after frozen write");
    $display("test decode done");
    wreg(OFS_AMP, 16'h0400);
    wreg(OFS_CCTL, 16'hffff);
    rreg(OFS_CCTL, 16'h1307, "converter_control");
    chk("conv on", 16'h000c, conv_outs & 16'h000c);
    wreg(OFS_CCTL, 16'h0000);
    rreg(OFS_CCTL, 16'h1306, "locked control");
    wreg(OFS_CCTL, 16'h0000);
    rreg(OFS_CCTL, 16'h0000, "unlocked control");
    wreg(OFS_CDAT, 16'hffff);
    chk("latch on data write", 16'hfff0, conv_outs);
    rreg(OFS_CDAT, 16'h0fff, "converter_data");
    rreg(OFS_CSTS, 16'h0000, "no flag on write load");
    wreg(OFS_CCTL, 16'h0207);
    wreg(OFS_CDAT, 16'h0123);
    chk("no load before trigger", 16'hfff8, conv_outs);
    pulse(0);
    chk("triggered load", 16'h123b, conv_outs);
    rreg(OFS_CSTS, 16'h0001, "flag set");
    rreg(OFS_IVEC, 16'h0002, "vector");
    rreg(OFS_CSTS, 16'h0000, "flag after vector read");
    pulse(2);
    chk("dma start", 16'h1238, conv_outs);
    wreg(OFS_CDAT, 16'h0456);
    pulse(1);
    chk("other trigger ignored", 16'h1238, conv_outs);
    pulse(0);
    pulse(2);
    chk("dma start clears flag", 16'h4568, conv_outs);
    pulse(0);
    wreg(OFS_CSTS, 16'h0001);
    rreg(OFS_CSTS, 16'h0000, "flag write one");
    chk("request after flag write", 16'h4569, conv_outs);
    pulse(2);
    $display("test trigger 0 done");
    wreg(OFS_CCTL, 16'h0000);
    wreg(OFS_CCTL, 16'h0303);
    wreg(OFS_CDAT, 16'h0abc);
    pulse(1);
    chk("trigger 1 load", 16'habca, conv_outs);
    wreg(OFS_CCTL, 16'h0000);
    wreg(OFS_CDAT, 16'h0def);
    pulse(1);
    chk("disabled trigger", 16'habc2, conv_outs);
    wreg(OFS_CCTL, 16'h0101);
    wreg(OFS_CDAT, 16'h0321);
    pulse(0);
    pulse(1);
    chk("reserved load select", 16'habc8, conv_outs);
    $display("test load select done");
    test_done();
  end
endmodule : test_analog_combo_register_bank
